// File: pkg/dds_regs.svh
// Register map, field positions, reset values and sync timing counts
// for the dynamic digital delay sync block.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
// Contract
// - Qualified sync waits for qualifier clock transition
// - Qualifier clock is the selected group output
// - Exempt qualifier group: absolute, its delay unchanged
// - Non-exempt qualifier group: relative, its delay reapplied
// - Exempt groups keep toggling during sync
// - Unqualified sync leaves phase to others undefined
// - Half-step change acts immediately, no sync
// - New delay count applies only at next sync
// - Auto sync: writing group registers starts sync
// - One-shot starts three cycles after qualification, lasts three
// - One-shot stops outputs, restarts after delay
// - Absolute mode keeps qualifier half-step constant
// - Absolute mode may glitch adjusted output at assertion
// - All counts are distribution clock cycles
// - Request held over one cycle, registered rising edge
// - Unqualified: outputs low six cycles after registration
// - Qualified: low five after start, rise five plus delay
`ifndef DDS_REGS_SVH
`define DDS_REGS_SVH

// Register byte offsets
`define DDS_GRP_BASE     8'h00
`define DDS_CTRL_OFS     8'h18
`define DDS_STAT_OFS     8'h1c

// Output group register fields
`define DDS_F_DIV_LSB    0
`define DDS_F_DDLY_LSB   8
`define DDS_F_HS_BIT     16
`define DDS_F_EXEMPT_BIT 17

// Control register fields
`define DDS_F_QUAL_EN    0
`define DDS_F_POL_INV    1
`define DDS_F_AUTO       2
`define DDS_F_QSEL_EN    3
`define DDS_F_QSEL_LSB   4
`define DDS_F_PD2        7

// Status register fields
`define DDS_F_BUSY       0
`define DDS_F_SHOT       1
`define DDS_F_PEND       2
`define DDS_F_LVL_LSB    8

// Reset values
`define DDS_DIV_RST      8'h02
`define DDS_DDLY_RST     6'h05

// Sync timing in distribution clock cycles
`define DDS_UNQ_STOP_CYC   4'h6
`define DDS_UNQ_START_CYC  4'h6
`define DDS_QUAL_PRE_CYC   4'h3
`define DDS_SHOT_CYC       4'h3
`define DDS_QUAL_STOP_CYC  4'h5
`define DDS_QUAL_START_CYC 4'h5

`endif

// File: pkg/dds_pkg.sv
// Types shared by the sync sequencer and the output group modules.
// Assumes a single distribution clock domain.
package dds_pkg;

    // Sync sequencer states
    typedef enum logic [2:0] {S_IDLE, S_HOLD, S_QWAIT, S_PRE, S_SHOT, S_TAIL} dds_seq_t;

    // Output group modes
    typedef enum logic [1:0] {G_RUN, G_STOP, G_WAIT} dds_grp_mode_t;

endpackage

// File: src/dds_clk_group.sv
// One output clock group: divider, stop on sync, restart after its delay.
// Assumes stop and restart are one-cycle pulses from the sequencer.
`timescale 1ns/1ps
module dds_clk_group
    import dds_pkg::*;
#(
    parameter int DIV_W = 8,
    parameter int DLY_W = 6
) (
    // Clock, reset, enable
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    // Configuration
    input  wire logic [DIV_W-1:0] divider,
    input  wire logic [DLY_W-1:0] ddly,
    input  wire logic             exempt,
    input  wire logic             power_down,
    // Sequencer events
    input  wire logic             stop,
    input  wire logic             restart,
    // Output clock level
    output logic                  clk_lvl
);
    typedef struct packed {
        dds_grp_mode_t    mode;
        logic [DIV_W-1:0] cnt;
        logic [DLY_W-1:0] dly;
        logic [DLY_W-1:0] live_dly;
        logic             clk;
    } dds_grp_st_t;

    localparam dds_grp_st_t ST_RST = '{mode: G_RUN, clk: 1'b1, default: '0};

    dds_grp_st_t      s_r;
    dds_grp_st_t      s_nxt;
    logic [DIV_W-1:0] div_eff;
    logic [DIV_W-1:0] high_len;

    generate
        if (DIV_W < 2 || DIV_W > 8 || DLY_W < 3 || DLY_W > 6) begin : g_bad
            $error("dds_clk_group: unsupported width");
        end
    endgenerate

    // Divide by one is served as divide by two; odd ratios are high one extra cycle
    assign div_eff  = (divider < DIV_W'(2)) ? DIV_W'(2) : divider;
    assign high_len = DIV_W'(({1'b0, div_eff} + 1'b1) >> 1);

    // Next state of the group
    always_comb begin
        s_nxt = s_r;
        case (s_r.mode)
            G_RUN: begin
                s_nxt.cnt = (s_r.cnt == div_eff - 1'b1) ? '0 : DIV_W'(s_r.cnt + 1'b1);
                s_nxt.clk = (s_nxt.cnt < high_len);
            end
            G_STOP: begin
                s_nxt.clk = 1'b0;
            end
            G_WAIT: begin
                if (s_r.dly <= DLY_W'(1)) begin
                    s_nxt.mode = G_RUN;          // Rise after the programmed delay
                    s_nxt.cnt  = '0;
                    s_nxt.clk  = 1'b1;
                end else begin
                    s_nxt.dly = DLY_W'(s_r.dly - 1'b1);
                end
            end
            default: begin
                s_nxt.mode = G_STOP;
                s_nxt.clk  = 1'b0;
            end
        endcase
        // Exempt groups ignore sync entirely
        if (!exempt && stop) begin
            s_nxt.mode = G_STOP;                 // Forced low
            s_nxt.clk  = 1'b0;
        end
        if (!exempt && restart) begin
            s_nxt.mode     = G_WAIT;             // Count taken only here
            s_nxt.live_dly = ddly;
            s_nxt.dly      = ddly;
            s_nxt.clk      = 1'b0;
        end
        // Powered down group is silent; after the bit clears it waits for a sync restart, which an exempt group never takes
        if (power_down) begin
            s_nxt.mode = G_STOP;
            s_nxt.clk  = 1'b0;
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= ST_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign clk_lvl = s_r.clk;

    a_restart_rise: assert property (@(posedge pclk) disable iff (!presetn || !ce)
        (restart && !stop && !exempt && !power_down && ddly == DLY_W'(5))
        |=> !s_r.clk [*5] ##1 s_r.clk)
        else $error("group did not rise five cycles after restart");

    a_exempt_runs: assert property (@(posedge pclk) disable iff (!presetn || !ce)
        (exempt && !power_down && s_r.mode == G_RUN && (stop || restart))
        |=> s_r.mode == G_RUN)
        else $error("exempt group interrupted by sync");

    a_delay_held: assert property (@(posedge pclk) disable iff (!presetn || !ce)
        (!restart || exempt) |=> s_r.live_dly == $past(s_r.live_dly))
        else $error("delay count changed without sync");
endmodule

// File: src/dds_sync_delay.sv
// Sync qualification and dynamic digital delay sequencer with APB registers.
// Assumes pclk is the distribution clock; sync_pin is asynchronous to it.
`timescale 1ns/1ps
`include "dds_regs.svh"
module dds_sync_delay
    import dds_pkg::*;
#(
    parameter int NGRP  = 6,
    parameter int DIV_W = 8,
    parameter int DLY_W = 6
) (
    // Clock, reset, enable
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    // APB slave
    input  wire logic [7:0]       paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Sync request pin
    input  wire logic             sync_pin,
    // Output clocks and status
    output logic      [NGRP-1:0]  clk_out,
    output logic      [NGRP-1:0]  half_step_out,
    output logic                  oneshot_active,
    output logic                  sync_busy
);
    typedef struct packed {
        logic [NGRP-1:0][DIV_W-1:0] div;
        logic [NGRP-1:0][DLY_W-1:0] ddly;
        logic [NGRP-1:0]            hs;
        logic [NGRP-1:0]            exempt;
        logic                       qual_en;
        logic                       pol_inv;
        logic                       auto_en;
        logic                       qsel_en;
        logic [2:0]                 qsel;
        logic                       pd2;
        logic                       s1;
        logic                       s2;
        logic                       req_prev;
        logic                       q_prev;
        dds_seq_t                   st;
        logic [3:0]                 cnt;
        logic [3:0]                 stop_cnt;
        logic [3:0]                 start_cnt;
        logic                       pend;
        logic                       shot;
        logic                       busy;
        logic [31:0]                rdata;
        logic                       ready;
        logic                       slverr;
    } dds_top_st_t;

    localparam dds_top_st_t ST_RST = '{
        div:  {NGRP{DIV_W'(`DDS_DIV_RST)}},
        ddly: {NGRP{DLY_W'(`DDS_DDLY_RST)}},
        st:   S_IDLE,
        default: '0
    };

    dds_top_st_t     s_r;
    dds_top_st_t     s_nxt;
    logic [NGRP-1:0] clk_lvl;
    logic            setup;
    logic            access;
    logic            wr_grp;
    logic            auto_ev;
    logic            req;
    logic            arm;
    logic            qclk;
    logic            q_fall;
    logic            stop_fire;
    logic            start_fire;

    generate
        // More than six groups would overlap the control and status words
        if (NGRP < 3 || NGRP > 6 || DIV_W < 2 || DIV_W > 8 || DLY_W < 3 || DLY_W > 6)
        begin : g_bad
            $error("dds_sync_delay: unsupported parameter");
        end
    endgenerate

    // Address decode shared by read and write paths
    function automatic logic grp_hit(input logic [7:0] a);
        grp_hit = (a[1:0] == 2'b00) && (a[7:2] < 6'(NGRP));
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = grp_hit(a) || a == `DDS_CTRL_OFS || a == `DDS_STAT_OFS;
    endfunction

    // Read data for one address; reserved bits read zero
    function automatic logic [31:0] rd_word(input logic [7:0]      a,
                                            input dds_top_st_t     s,
                                            input logic [NGRP-1:0] lv);
        logic [31:0] w;
        logic [2:0]  g;
        w = '0;
        g = a[4:2];
        if (grp_hit(a)) begin
            w[`DDS_F_DIV_LSB +: DIV_W]  = s.div[g];
            w[`DDS_F_DDLY_LSB +: DLY_W] = s.ddly[g];
            w[`DDS_F_HS_BIT]            = s.hs[g];
            w[`DDS_F_EXEMPT_BIT]        = s.exempt[g];
        end else if (a == `DDS_CTRL_OFS) begin
            w[`DDS_F_QUAL_EN]         = s.qual_en;
            w[`DDS_F_POL_INV]         = s.pol_inv;
            w[`DDS_F_AUTO]            = s.auto_en;
            w[`DDS_F_QSEL_EN]         = s.qsel_en;
            w[`DDS_F_QSEL_LSB +: 3]   = s.qsel;
            w[`DDS_F_PD2]             = s.pd2;
        end else if (a == `DDS_STAT_OFS) begin
            w[`DDS_F_BUSY]            = s.busy;
            w[`DDS_F_SHOT]            = s.shot;
            w[`DDS_F_PEND]            = s.pend;
            w[`DDS_F_LVL_LSB +: NGRP] = lv;
        end
        rd_word = w;
    endfunction

    // Bus phases; the slave answers with no wait state
    assign setup   = psel && !penable;
    assign access  = psel && penable && s_r.ready;
    assign wr_grp  = access && pwrite && grp_hit(paddr);
    assign auto_ev = wr_grp && s_r.auto_en;                   // Write starts a sync

    // Request level: pin through two flops, then polarity; an invert toggle also asserts
    assign req = s_r.s2 ^ s_r.pol_inv;
    assign arm = (req && !s_r.req_prev) || auto_ev;

    // Qualifier: output clock chosen by the selector; its falling edge qualifies
    assign qclk   = (s_r.qsel < 3'(NGRP)) ? clk_lvl[s_r.qsel] : 1'b0;
    assign q_fall = s_r.q_prev && !qclk;

    // Stop and restart timers fire on their last count
    assign stop_fire  = (s_r.stop_cnt == 4'h1);
    assign start_fire = (s_r.start_cnt == 4'h1);

    // Next state: registers, synchroniser, sequencer
    always_comb begin
        s_nxt = s_r;
        // APB answer prepared in the setup phase
        s_nxt.ready  = setup;
        s_nxt.slverr = setup && !mapped(paddr);
        if (setup) begin
            s_nxt.rdata = rd_word(paddr, s_r, clk_lvl);
        end
        if (wr_grp) begin
            s_nxt.div[paddr[4:2]]    = pwdata[`DDS_F_DIV_LSB +: DIV_W];
            s_nxt.ddly[paddr[4:2]]   = pwdata[`DDS_F_DDLY_LSB +: DLY_W];
            s_nxt.hs[paddr[4:2]]     = pwdata[`DDS_F_HS_BIT];     // Shown at once
            s_nxt.exempt[paddr[4:2]] = pwdata[`DDS_F_EXEMPT_BIT];
        end
        if (access && pwrite && paddr == `DDS_CTRL_OFS) begin
            s_nxt.qual_en = pwdata[`DDS_F_QUAL_EN];
            s_nxt.pol_inv = pwdata[`DDS_F_POL_INV];
            s_nxt.auto_en = pwdata[`DDS_F_AUTO];
            s_nxt.qsel_en = pwdata[`DDS_F_QSEL_EN];
            s_nxt.qsel    = pwdata[`DDS_F_QSEL_LSB +: 3];
            s_nxt.pd2     = pwdata[`DDS_F_PD2];
        end

        // Synchroniser and edge memories
        s_nxt.s1       = sync_pin;
        s_nxt.s2       = s_r.s1;
        s_nxt.req_prev = req;
        s_nxt.q_prev   = qclk;

        // Timers count down in distribution cycles
        s_nxt.stop_cnt  = (s_r.stop_cnt != 4'h0) ? 4'(s_r.stop_cnt - 1'b1) : 4'h0;
        s_nxt.start_cnt = (s_r.start_cnt != 4'h0) ? 4'(s_r.start_cnt - 1'b1) : 4'h0;

        case (s_r.st)
            S_IDLE: begin
                if (arm || s_r.pend) begin
                    s_nxt.pend = s_r.pend && arm;             // Coinciding request kept
                    if (s_r.qual_en) begin
                        s_nxt.st = S_QWAIT;                   // Wait for qualifier
                    end else begin
                        // Phase to unsynced groups is left undefined here
                        s_nxt.stop_cnt = `DDS_UNQ_STOP_CYC;
                        s_nxt.st       = S_HOLD;
                    end
                end
            end
            S_HOLD: begin
                // Outputs stay low for as long as the level request stands
                if (!req) begin
                    s_nxt.start_cnt = `DDS_UNQ_START_CYC;
                    s_nxt.st        = S_TAIL;
                end
            end
            S_QWAIT: begin
                if (q_fall) begin
                    s_nxt.cnt = `DDS_QUAL_PRE_CYC;
                    s_nxt.st  = S_PRE;
                end
            end
            S_PRE: begin
                if (s_r.cnt == 4'h1) begin
                    s_nxt.cnt      = `DDS_SHOT_CYC;           // One-shot begins
                    s_nxt.shot     = 1'b1;
                    s_nxt.stop_cnt = `DDS_QUAL_STOP_CYC;
                    s_nxt.st       = S_SHOT;
                end else begin
                    s_nxt.cnt = 4'(s_r.cnt - 1'b1);
                end
            end
            S_SHOT: begin
                if (s_r.cnt == 4'h1) begin
                    s_nxt.shot      = 1'b0;
                    s_nxt.start_cnt = `DDS_QUAL_START_CYC;
                    s_nxt.st        = S_TAIL;
                end else begin
                    s_nxt.cnt = 4'(s_r.cnt - 1'b1);
                end
            end
            S_TAIL: begin
                // Sequence ends only after both timers have fired
                if (s_r.stop_cnt == 4'h0 && s_r.start_cnt == 4'h0) begin
                    s_nxt.st = S_IDLE;
                end
            end
            default: begin
                s_nxt.st   = S_IDLE;
                s_nxt.shot = 1'b0;
            end
        endcase

        // A request during a running sequence is kept in one pending bit, so repeats merge
        if (arm && s_r.st != S_IDLE) begin
            s_nxt.pend = 1'b1;
        end
        s_nxt.busy = (s_nxt.st != S_IDLE);
    end

    // State register; ce low freezes everything, bus included
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= ST_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Output groups; group two honours its power-down bit
    for (genvar g = 0; g < NGRP; g++) begin : g_grp
        dds_clk_group #(
            .DIV_W (DIV_W),
            .DLY_W (DLY_W)
        ) u_grp (
            .pclk       (pclk),
            .presetn    (presetn),
            .ce         (ce),
            .divider    (s_r.div[g]),
            .ddly       (s_r.ddly[g]),
            .exempt     (s_r.exempt[g]),
            .power_down ((g == 2) ? s_r.pd2 : 1'b0),
            .stop       (stop_fire),
            .restart    (start_fire),
            .clk_lvl    (clk_lvl[g])
        );
    end

    // Absolute mode may show a short pulse when the stop lands mid-high
    // Half-step has no sync gating, so absolute qualifier stays fixed
    assign clk_out        = clk_lvl;
    assign half_step_out  = s_r.hs;
    assign oneshot_active = s_r.shot;
    assign sync_busy      = s_r.busy;
    assign prdata         = s_r.rdata;
    assign pready         = s_r.ready;
    assign pslverr        = s_r.slverr;

    default clocking dds_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !ce);

    a_shot_width: assert property ($rose(s_r.shot) |-> s_r.shot [*3] ##1 !s_r.shot)
        else $error("one-shot width is not three cycles");

    a_shot_after_qual: assert property (
        (s_r.st == S_QWAIT && q_fall) |=> !s_r.shot [*3] ##1 s_r.shot)
        else $error("one-shot did not start three cycles after qualification");

    a_qual_stop: assert property ($rose(s_r.shot) |-> ##4 stop_fire)
        else $error("qualified stop not five cycles after one-shot start");

    a_qual_start: assert property ($fell(s_r.shot) |-> ##4 start_fire)
        else $error("qualified restart not five cycles after one-shot end");

    a_unq_stop: assert property (
        (s_r.st == S_IDLE && arm && !s_r.pend && !s_r.qual_en) |-> ##6 stop_fire)
        else $error("unqualified stop not six cycles after registration");

    a_qual_waits: assert property (
        (s_r.st == S_QWAIT) |-> (stop_fire == 1'b0) && !s_r.shot)
        else $error("sync acted before qualifier edge");

    a_auto_sync: assert property (
        (wr_grp && s_r.auto_en) |=> (s_r.st != S_IDLE || s_r.pend))
        else $error("group write with auto sync did not start a sync");

    a_hold_pend: assert property (
        (arm && s_r.st != S_IDLE) |=> s_r.pend)
        else $error("request during sequence was lost");

    a_half_step: assert property (
        (wr_grp && paddr[4:2] == 3'h0) |=> half_step_out[0] == $past(pwdata[`DDS_F_HS_BIT]))
        else $error("half-step write not applied at once");
endmodule

// File: testbench/dds_host_model.sv
// Host side of the sync pin: turns a one-cycle go strobe into a held request.
// Assumes go and hold_len are driven by the bench just after a rising edge.
`timescale 1ns/1ps
module dds_host_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Request from the bench
    input  wire logic       go,
    input  wire logic [3:0] hold_len,
    // Pin towards the device
    output logic            sync_pin
);
    logic [3:0] hold_r;

    // Hold the pin for hold_len cycles; callers keep it at two or more
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 4'h0;
        end else if (go) begin
            hold_r <= hold_len;
        end else if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
        end
    end

    // Polarity invert is clear during pin requests, so active high and idle low
    assign sync_pin = (hold_r != 4'h0);
endmodule

// File: testbench/dynamic_digital_delay_sync_test.sv
// Self-checking bench for the sync sequencer: APB host, pin model, timing checks.
// Assumes default parameters and ce held high throughout.
`timescale 1ns/1ps
module dynamic_digital_delay_sync_test
    import dds_pkg::*;
;
    logic        pclk, presetn, ce, psel, penable, pwrite, go, prev0;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat, rnd;
    logic        pready, pslverr, rerr, sync_pin, oneshot_active, sync_busy;
    logic [5:0]  clk_out, half_step_out;
    logic [3:0]  hold_len;
    logic [5:0]  d;
    int          errors, checked, cycles;

    dds_sync_delay dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_pin(sync_pin),
        .clk_out(clk_out), .half_step_out(half_step_out),
        .oneshot_active(oneshot_active), .sync_busy(sync_busy));
    dds_host_model host (.pclk(pclk), .presetn(presetn), .go(go),
        .hold_len(hold_len), .sync_pin(sync_pin));

    // Clock at 4 ns
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Group word: divider 2, given delay, half step and exempt bits
    function automatic logic [31:0] grp(input logic [5:0] dl, input logic hs, input logic ex);
        return {14'h0, ex, hs, 2'h0, dl, 8'h02};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; returns at the edge where pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait ends when pready is sampled high, or by the hang guard
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pin request with a random hold, launched at the next edge
    task automatic pin_req();
        rnd = lfsr(rnd);
        fork
            begin
                @(posedge pclk);
                go <= 1'b1;
                hold_len <= 4'h2 + {1'b0, rnd[5:4], 1'b0};
                @(posedge pclk);
                go <= 1'b0;
            end
        join_none
    endtask

    task automatic wait_idle();
        while (sync_busy !== 1'b0) begin
            @(negedge pclk);
        end
    endtask

    // Qualified sync; again adds a request while the one-shot is high
    task automatic qual_run(input logic [31:0] ctrl, input bit again);
        int n, m;
        rnd = lfsr(rnd);
        d = 6'd3 + {2'h0, rnd[3:0] % 4'd10};
        apb(1'b1, 8'h18, ctrl);
        apb(1'b1, 8'h00, grp(6'd5, 1'b0, 1'b1));
        apb(1'b1, 8'h04, grp(d, 1'b0, 1'b0));
        pin_req();
        n = 0;
        while (oneshot_active !== 1'b1 && n < 200) begin
            @(negedge pclk);
            n++;
        end
        check(n < 200, 1, "no one-shot after qualified request");
        if (again) begin
            pin_req();
        end
        n = 0;
        while (oneshot_active === 1'b1 && n < 10) begin
            @(negedge pclk);
            n++;
        end
        check(n, 3, "one-shot width");
        repeat (2) @(negedge pclk);
        check(clk_out[1], 1'b0, "synced group not held low");
        m = 2;
        while (clk_out[1] !== 1'b1 && m < 40) begin
            @(negedge pclk);
            m++;
        end
        check(m, 5 + d, "restart delay after one-shot");
        if (again) begin
            n = 0;
            while (oneshot_active !== 1'b1 && n < 300) begin
                @(negedge pclk);
                n++;
            end
            check(n < 300, 1, "held request never ran");
        end
        wait_idle();
    endtask

    // Exempt group 0 at divider 2 must toggle every cycle while busy
    always @(negedge pclk) begin
        if (sync_busy === 1'b1) begin
            check(clk_out[0], {31'h0, ~prev0}, "exempt group stalled");
        end
        prev0 <= clk_out[0];
    end

    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    initial begin
        int j;
        {presetn, psel, penable, pwrite, go, prev0} = 6'h00;
        ce = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        hold_len = 4'h2;
        rnd = 32'hf3fd2ef2;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, unmapped access, half step at once, no sync on write
        apb(1'b0, 8'h04, 32'h0);
        check(rdat, 32'h0000_0502, "group reset value");
        apb(1'b0, 8'h20, 32'h0);
        check({rdat, rerr}, 33'h0_0000_0001, "unmapped read");
        apb(1'b1, 8'h04, grp(6'd9, 1'b1, 1'b0));
        repeat (2) @(negedge pclk);
        check(half_step_out[1], 1'b1, "half step not immediate");
        check(sync_busy, 1'b0, "sync started without request");
        $display("test registers done");
        qual_run(32'h0000_0009, 1'b0);
        $display("test absolute done");
        qual_run(32'h0000_0019, 1'b1);
        $display("test relative done");
        // Auto sync on group write, unqualified timing
        apb(1'b1, 8'h18, 32'h0000_0004);
        rnd = lfsr(rnd);
        d = 6'd3 + {2'h0, rnd[3:0] % 4'd10};
        apb(1'b1, 8'h04, grp(d, 1'b0, 1'b0));
        for (j = 0; j <= 7 + d; j++) begin
            @(negedge pclk);
            if (j == 2) check(sync_busy, 1'b1, "auto sync not started");
            if (j >= 6 && j <= 6 + d) check(clk_out[1], 1'b0, "not held low");
        end
        check(clk_out[1], 1'b1, "auto restart late");
        wait_idle();
        $display("test auto sync done");
        // Polarity bit toggle holds synced groups low until cleared
        apb(1'b1, 8'h18, 32'h0000_0002);
        repeat (8) @(negedge pclk);
        check(clk_out[1], 1'b0, "polarity toggle not held low");
        apb(1'b1, 8'h18, 32'h0000_0000);
        wait_idle();
        repeat (d - 1) @(negedge pclk);
        check(clk_out[1], 1'b1, "polarity release restart late");
        $display("test polarity done");
        stop_test();
    end
endmodule
